// ---- vrc_top.sv ----
`timescale 1ns/10ps
`include "vrc_defines.svh"
// Operation
// - eight registers, 128 elements, 64 bits, split
// - even and odd elements move together
// - delivered element count equals element length
// - both slices load length from operand bits 6:0
// - zero length forces full 200 octal
// - countdown loads half the length, rounded up
// - each decrement emits one step pulse
// - last operation pipe picked by length parity
// - even length writes both pipes together
// - operand reserved as destination still issues
// - matching element forwarded to read-out register
// - write launch timing regulates chaining
// - memory chaining counts 8-word groups but never waits
// - one-parcel instruction fields decoded
// - prefix selects extended shift count source
// - element to scalar and scalar to element moves
// - even slice releases write regs and units
// - odd slice releases read regs and units
module vrc_top
  import vrc_pkg::*;
#(
  parameter int NREG = 8,
  parameter int NELEM = 128,
  parameter int DW = 64
)(
  input wire logic i_core_clk, // core clock
  input wire logic i_rst_n, // async reset, active low
  input wire logic i_issue, // instruction parcel valid
  output logic o_issue_ready, // parcel accepted
  input wire logic [15:0] i_parcel, // instruction parcel
  input wire logic [63:0] i_addr_operand_k, // k address operand
  input wire logic [63:0] i_scalar_source_j, // scalar operand
  input wire logic i_sv_elem_sel, // transfer element index valid
  input wire logic [6:0] i_sv_elem, // transfer element index
  input wire logic i_len_load, // load element length
  input wire logic i_mem_word_valid, // memory load word valid
  input wire logic i_res_valid, // pipe results valid
  input wire logic [DW-1:0] i_res_even, // even pipe result
  input wire logic [DW-1:0] i_res_odd, // odd pipe result
  input wire logic i_fwd_req, // waiting reader wants result
  input wire logic i_out_ready, // receiver takes operand pair
  output logic o_out_valid, // operand pair valid
  output logic [DW-1:0] o_out_even, // even operand
  output logic [DW-1:0] o_out_odd, // odd operand
  output logic o_elem_step, // advance element address
  output logic o_go_write, // write launch
  output logic [1:0] o_pipe_en, // pipe1, pipe0 enables
  output logic [5:0] o_elem_addr, // per-pipe element address
  output logic [7:0] o_elem_length_count, // element length
  output logic o_ext_mode, // extended mode active
  output logic o_shift_from_vreg, // shift count from reg zero
  output logic [DW-1:0] o_scalar_data, // element read to scalar
  output logic o_scalar_valid, // scalar data valid
  output logic [NREG-1:0] o_write_release, // even slice
  output logic [NREG-1:0] o_read_release, // odd slice
  output vrc_even_rel_t o_even_unit_rel, // even unit release
  output vrc_odd_rel_t o_odd_unit_rel, // odd unit release
  output logic o_busy // operation running
);
  // ==========================================================
  // reset release
  logic rst_meta_ff, rst_sync_ff;
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  wire rst_n = rst_sync_ff;

  // ==========================================================
  // decode
  vrc_parcel_t par;
  assign par = vrc_parcel_t'(i_parcel);
  function automatic logic [NREG-1:0] dec8(input logic [2:0] a);
    dec8 = NREG'(1) << a;
  endfunction
  wire is_prefix = i_parcel == `VRC_EXT_PREFIX;
  wire is_v2s = par.opcode_field == `VRC_OP_V2S;
  wire is_s2v = par.opcode_field == `VRC_OP_S2V;
  wire is_shl = par.opcode_field == `VRC_OP_SHL;
  wire [6:0] len_field = i_addr_operand_k[`VRC_LEN_LSB +: `VRC_LEN_W];
  wire [7:0] len_in = (len_field == 7'h00) ? `VRC_LEN_FULL : {1'b0, len_field};

  // ==========================================================
  // storage: even and odd banks
  logic [DW-1:0] even_mem [NREG][NELEM/2];
  logic [DW-1:0] odd_mem [NREG][NELEM/2];

  // ==========================================================
  // control slice state
  vrc_state_t state_ff, nxt_state;
  logic [7:0] len_ff;
  logic [6:0] cnt_ff;
  logic [5:0] addr_ff;
  logic ext_ff, shl_ff;
  logic [2:0] dst_ff, src_ff;
  logic [NREG-1:0] rsv_ff;
  logic [3:0] grp_ff;
  logic grp_ok_ff;
  logic [DW-1:0] sdata_ff;
  logic svalid_ff;

  // two-entry skid buffer
  logic [2*DW-1:0] buf_ff [2];
  logic [1:0] bcnt_ff;
  logic bhead_ff;
  wire buf_full = bcnt_ff == 2'd2;
  wire buf_in = state_ff == VRC_RUN && !buf_full && grp_ok_ff;
  wire buf_out = bcnt_ff != 2'd0 && i_out_ready;
  wire last_op = cnt_ff == 7'd1;
  wire step = buf_in;
  wire start = i_issue && state_ff == VRC_IDLE && !is_prefix
    && !is_v2s && !is_s2v;
  // chaining: issue even if source reserved as destination
  assign o_issue_ready = state_ff == VRC_IDLE;
  wire fwd = i_fwd_req && i_res_valid;

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      VRC_IDLE: if (start) nxt_state = VRC_RUN;
      VRC_RUN: if (step && last_op) nxt_state = VRC_DONE;
      VRC_DONE: nxt_state = VRC_IDLE;
      default: nxt_state = VRC_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= VRC_IDLE;
      len_ff <= `VRC_RST_LEN;
      cnt_ff <= `VRC_RST_CNT;
      addr_ff <= 6'h00;
      ext_ff <= 1'b0;
      shl_ff <= 1'b0;
      dst_ff <= 3'h0;
      src_ff <= 3'h0;
      rsv_ff <= `VRC_RST_RSV;
      grp_ff <= 4'h0;
      grp_ok_ff <= 1'b1;
      svalid_ff <= 1'b0;
      sdata_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      svalid_ff <= 1'b0;
      if (i_len_load)
        len_ff <= len_in;
      if (i_issue && o_issue_ready && is_prefix)
        ext_ff <= 1'b1;
      else if (start)
      begin
        ext_ff <= 1'b0;
        shl_ff <= ext_ff && is_shl && par.k == 3'h0;
        dst_ff <= par.i;
        src_ff <= par.k;
        cnt_ff <= len_ff[7:1] + {6'h00, len_ff[0]};
        addr_ff <= 6'h00;
        rsv_ff <= rsv_ff | dec8(par.i);
        grp_ff <= 4'h0;
        grp_ok_ff <= 1'b1;
      end
      if (i_issue && o_issue_ready && is_v2s && i_sv_elem_sel)
      begin
        sdata_ff <= i_sv_elem[0] ? odd_mem[par.k][i_sv_elem[6:1]]
          : even_mem[par.k][i_sv_elem[6:1]];
        svalid_ff <= 1'b1;
      end
      if (step)
      begin
        cnt_ff <= cnt_ff - 7'd1;
        addr_ff <= addr_ff + 6'd1;
      end
      if (i_mem_word_valid)
      begin
        grp_ff <= (grp_ff == 4'(`VRC_GROUP_WORDS - 1)) ? 4'h0
          : grp_ff + 4'd1;
        if (grp_ff == 4'(`VRC_GROUP_WORDS - 1))
          grp_ok_ff <= 1'b1;
      end
      if (state_ff == VRC_DONE)
        rsv_ff <= rsv_ff & ~dec8(dst_ff);
    end
  end

  // results written as pairs into even and odd banks, even bank only on the last op of an odd length
  always_ff @(posedge i_core_clk)
  begin
    if (i_res_valid && state_ff == VRC_RUN)
    begin
      even_mem[dst_ff][addr_ff] <= i_res_even;
      if (!(last_op && len_ff[0]))
        odd_mem[dst_ff][addr_ff] <= i_res_odd;
    end
    if (i_issue && o_issue_ready && is_s2v && i_sv_elem_sel)
    begin
      if (i_sv_elem[0])
        odd_mem[par.i][i_sv_elem[6:1]] <= i_scalar_source_j;
      else
        even_mem[par.i][i_sv_elem[6:1]] <= i_scalar_source_j;
    end
  end

  // operand read-out with forwarding of the fresh result
  wire [DW-1:0] rd_even = fwd ? i_res_even : even_mem[src_ff][addr_ff];
  wire [DW-1:0] rd_odd = fwd ? i_res_odd : odd_mem[src_ff][addr_ff];

  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bcnt_ff <= 2'd0;
      bhead_ff <= 1'b0;
    end
    else
    begin
      bcnt_ff <= bcnt_ff + {1'b0, buf_in} - {1'b0, buf_out};
      if (buf_out)
        bhead_ff <= ~bhead_ff;
    end
  end
  wire btail = bhead_ff ^ bcnt_ff[0];
  always_ff @(posedge i_core_clk)
  begin
    if (buf_in)
      buf_ff[btail] <= {rd_odd, rd_even};
  end
  assign o_out_valid = bcnt_ff != 2'd0;
  assign o_out_even = buf_ff[bhead_ff][DW-1:0];
  assign o_out_odd = buf_ff[bhead_ff][2*DW-1:DW];

  // ==========================================================
  // outputs
  assign o_elem_step = step;
  assign o_go_write = step && grp_ok_ff;
  assign o_pipe_en = !step ? 2'b00
    : !last_op ? 2'b11
    : len_ff[0] ? 2'b01 : 2'b11;
  assign o_elem_addr = addr_ff;
  assign o_elem_length_count = len_ff;
  assign o_ext_mode = ext_ff;
  assign o_shift_from_vreg = shl_ff;
  assign o_scalar_data = sdata_ff;
  assign o_scalar_valid = svalid_ff;
  assign o_busy = state_ff != VRC_IDLE;
  wire done = state_ff == VRC_DONE;
  assign o_write_release = done ? dec8(dst_ff) : '0;
  assign o_read_release = done ? dec8(src_ff) : '0;
  assign o_even_unit_rel = done ? vrc_even_rel_t'(4'hF) : '0;
  assign o_odd_unit_rel = done ? vrc_odd_rel_t'(4'hF) : '0;

  // ==========================================================
  // checks
  chk_zero_full: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    i_len_load && len_field == 7'h00 |=> len_ff == 8'h80)
    else $error("zero length not forced to full");
  chk_len_load: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    i_len_load |=> len_ff[6:0] == $past(len_field))
    else $error("length not loaded from operand");
  chk_cnt_half: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    start |=> cnt_ff == $past(len_ff[7:1]) + $past({6'h00, len_ff[0]}))
    else $error("countdown load wrong");
  chk_step_dec: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    step |=> cnt_ff == $past(cnt_ff) - 7'd1)
    else $error("step without decrement");
  chk_last_pipe: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    step && last_op && len_ff[0] |-> o_pipe_en == 2'b01)
    else $error("odd length last op pipe wrong");
  chk_even_both: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    step && !len_ff[0] |-> o_pipe_en == 2'b11)
    else $error("even length not both pipes");
  chk_run_ends: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    step && last_op |=> state_ff == VRC_DONE ##1 !o_busy)
    else $error("run did not end on count");
  chk_launch_grp: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    o_go_write |-> grp_ok_ff && o_elem_step)
    else $error("write launch without step");
  chk_issue_rsv: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    state_ff == VRC_IDLE && rsv_ff != '0 |-> o_issue_ready)
    else $error("reserved register stalled issue");
  chk_ext_sel: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    start && ext_ff && is_shl && par.k == 3'h0 |=> o_shift_from_vreg)
    else $error("extended shift source missed");
  chk_rel_done: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    step && last_op |=> o_write_release == dec8(dst_ff))
    else $error("write release missing");
endmodule

// ---- vrc_defines.svh ----
`ifndef VRC_DEFINES_SVH
`define VRC_DEFINES_SVH
// element length field of the k address operand
`define VRC_LEN_LSB 0
`define VRC_LEN_W 7
// full register length, forced when the loaded field is zero
`define VRC_LEN_FULL 8'h80
// reset values
`define VRC_RST_LEN 8'h80
`define VRC_RST_CNT 7'h00
`define VRC_RST_RSV 8'h00
// memory chaining group size in words
`define VRC_GROUP_WORDS 8
// prefix parcel that selects extended mode
`define VRC_EXT_PREFIX 16'h0B00
// opcode field values (upper seven bits of a parcel)
`define VRC_OP_SHL 7'h68
`define VRC_OP_V2S 7'h3E
`define VRC_OP_S2V 7'h3F
`endif

// ---- vrc_pkg.sv ----
package vrc_pkg;
  typedef struct packed {
    logic [6:0] opcode_field;
    logic [2:0] i;
    logic [2:0] j;
    logic [2:0] k;
  } vrc_parcel_t;
  typedef struct packed {
    logic lu1;
    logic shift;
    logic fmul;
    logic recip;
  } vrc_even_rel_t;
  typedef struct packed {
    logic lu2;
    logic add;
    logic fadd;
    logic bmm;
  } vrc_odd_rel_t;
  typedef enum logic [2:0] {
    VRC_IDLE = 3'b001,
    VRC_RUN = 3'b010,
    VRC_DONE = 3'b100
  } vrc_state_t;
endpackage

// ---- vrc_unit_model.sv ----
`timescale 1ns/10ps
// ==========================================
// far side: units and memory, stalling at random
module vrc_unit_model
#(
  parameter int DW = 64
)(
  input wire logic i_core_clk, // core clock
  input wire logic i_busy, // operation running
  output logic o_out_ready, // takes operand pair
  output logic o_res_valid, // result pair valid
  output logic [DW-1:0] o_res_even, // even result
  output logic [DW-1:0] o_res_odd, // odd result
  output logic o_mem_word_valid, // memory word valid
  output logic o_fwd_req // reader wants forward
);
  initial
  begin
    o_out_ready = 1'b1;
    o_res_valid = 1'b0;
    o_res_even = '0;
    o_res_odd = '0;
    o_mem_word_valid = 1'b0;
    o_fwd_req = 1'b0;
  end
  // data changes every cycle so a stale word never looks valid
  always @(posedge i_core_clk)
  begin
    o_out_ready <= ($urandom % 4) != 0;
    o_res_valid <= i_busy && ($urandom % 2);
    o_res_even <= {$urandom, $urandom};
    o_res_odd <= {$urandom, $urandom};
    o_mem_word_valid <= ($urandom % 3) == 0;
    o_fwd_req <= ($urandom % 8) == 0;
  end
endmodule

// ---- vector_register_control_bench.sv ----
`timescale 1ns/10ps
module vector_register_control_bench;
  import vrc_pkg::*;
`define CHK(nm, e, g) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) \
    begin \
      n_errors++; \
      $display("MISMATCH %s exp %0h got %0h", nm, e, g); \
    end \
  end
  logic i_core_clk, i_rst_n, i_issue, i_sv_elem_sel, i_len_load;
  logic i_mem_word_valid, i_res_valid, i_fwd_req, i_out_ready;
  logic [15:0] i_parcel;
  logic [63:0] i_addr_operand_k, i_scalar_source_j, i_res_even, i_res_odd;
  logic [6:0] i_sv_elem;
  logic o_issue_ready, o_out_valid, o_elem_step, o_go_write, o_ext_mode;
  logic o_shift_from_vreg, o_scalar_valid, o_busy;
  logic [63:0] o_out_even, o_out_odd, o_scalar_data, exp_d;
  logic [1:0] o_pipe_en;
  logic [5:0] o_elem_addr;
  logic [7:0] o_elem_length_count, o_write_release, o_read_release, exp_s;
  vrc_even_rel_t o_even_unit_rel;
  vrc_odd_rel_t o_odd_unit_rel;
  logic [7:0] q_step[$], q_rel[$];
  logic [63:0] q_sc[$];
  logic [6:0] lens[5] = '{7'h00, 7'h01, 7'h02, 7'h7F, 7'h35};
  int n_errors = 0, samples_checked = 0, cyc = 0;

  vrc_top i_vrc_top (.i_core_clk, .i_rst_n, .i_issue, .o_issue_ready,
    .i_parcel, .i_addr_operand_k, .i_scalar_source_j, .i_sv_elem_sel,
    .i_sv_elem, .i_len_load, .i_mem_word_valid, .i_res_valid, .i_res_even,
    .i_res_odd, .i_fwd_req, .i_out_ready, .o_out_valid, .o_out_even,
    .o_out_odd, .o_elem_step, .o_go_write, .o_pipe_en, .o_elem_addr,
    .o_elem_length_count, .o_ext_mode, .o_shift_from_vreg, .o_scalar_data,
    .o_scalar_valid, .o_write_release, .o_read_release, .o_even_unit_rel,
    .o_odd_unit_rel, .o_busy);
  vrc_unit_model i_vrc_unit_model (.i_core_clk, .i_busy(o_busy),
    .o_out_ready(i_out_ready), .o_res_valid(i_res_valid),
    .o_res_even(i_res_even), .o_res_odd(i_res_odd),
    .o_mem_word_valid(i_mem_word_valid), .o_fwd_req(i_fwd_req));

  always #5 i_core_clk = ~i_core_clk;

  task automatic end_sim();
    $display("checked %0d, errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ==========================================
  // monitor: takes the oldest note per result
  // sampled mid-cycle, where combinational outputs have settled
  always @(negedge i_core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_errors++;
      end_sim();
    end
    if (o_elem_step === 1'b1)
    begin
      exp_s = (q_step.size() > 0) ? q_step.pop_front() : 8'hFF;
      `CHK("step", exp_s, {o_pipe_en, o_elem_addr})
      `CHK("go write", 1'b1, o_go_write)
    end
    if (o_write_release !== 8'h00)
    begin
      exp_s = (q_rel.size() > 0) ? q_rel.pop_front() : 8'h00;
      `CHK("release", exp_s, o_write_release)
      `CHK("read release", 8'h01, o_read_release)
      `CHK("even units", 4'hF, o_even_unit_rel)
      `CHK("odd units", 4'hF, o_odd_unit_rel)
    end
    if (o_scalar_valid === 1'b1)
    begin
      exp_d = (q_sc.size() > 0) ? q_sc.pop_front() : ~o_scalar_data;
      `CHK("scalar", exp_d, o_scalar_data)
    end
  end

  // ==========================================
  // drivers
  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask

  task automatic issue(input logic [15:0] p);
    while (o_issue_ready !== 1'b1) @(posedge i_core_clk);
    i_issue <= 1'b1;
    i_parcel <= p;
    tick(1);
    i_issue <= 1'b0;
    tick(2);
    while (o_busy !== 1'b0) @(posedge i_core_clk);
    tick(3);
  endtask

  task automatic run_op(input logic [6:0] l, input logic [6:0] op,
                        input logic pfx);
    int n;
    logic [2:0] r;
    r = 3'($urandom);
    i_len_load <= 1'b1;
    i_addr_operand_k <= {$urandom, 25'h0, l};
    tick(1);
    i_len_load <= 1'b0;
    tick(1);
    `CHK("length", (l == 7'h00) ? 8'h80 : {1'b0, l}, o_elem_length_count)
    n = (l == 7'h00) ? 64 : (l + 1) / 2;
    for (int s = 0; s < n; s++)
      q_step.push_back({(s == n - 1 && l[0]) ? 2'b01 : 2'b11, 6'(s)});
    q_rel.push_back(8'h01 << r);
    if (pfx)
      issue(16'h0B00);
    issue({op, r, r, 3'h0});
    `CHK("steps left", 0, q_step.size())
  endtask

  // ==========================================
  // main sequence
  initial
  begin
    i_core_clk = 1'b0;
    {i_rst_n, i_issue, i_sv_elem_sel, i_len_load} = 4'h0;
    {i_parcel, i_addr_operand_k, i_scalar_source_j, i_sv_elem} = '0;
    void'($urandom(32'hEC91F40D));
    tick(4);
    i_rst_n <= 1'b1;
    tick(3);
    `CHK("reset", 19'h00080, {o_busy, o_elem_step, o_go_write,
      o_write_release, o_elem_length_count})
    foreach (lens[t])
      run_op(lens[t], 7'h20, 1'b0);
    $display("length and step test done");
    run_op(7'($urandom), 7'h68, 1'b1);
    `CHK("shift src ext", 1'b1, o_shift_from_vreg)
    run_op(7'($urandom), 7'h68, 1'b0);
    `CHK("shift src plain", 1'b0, o_shift_from_vreg)
    $display("extended mode test done");
    repeat (4)
    begin
      exp_d = {$urandom, $urandom};
      i_sv_elem_sel <= 1'b1;
      i_sv_elem <= 7'($urandom);
      i_scalar_source_j <= exp_d;
      q_sc.push_back(exp_d);
      issue({7'h3F, 9'h1FF});
      issue({7'h3E, 9'h1FF});
    end
    i_sv_elem_sel <= 1'b0;
    `CHK("scalar left", 0, q_sc.size())
    $display("transfer test done");
    end_sim();
  end
endmodule
